// File: core/hp_seq_pkg.sv
// Constants shared by the heating-mode defrost sequencer and its helpers.
// Assumes temperatures are signed two's complement in 0.1 degC steps.
package hp_seq_pkg;

   // ****************************************************************
   // Clock and timebase
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SECOND_NS     = 1_000_000_000;
   localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
   localparam int unsigned SEC_PER_MIN   = 60;
   localparam int unsigned SEC_PER_HOUR  = 3600;

   // ****************************************************************
   // Temperatures, 0.1 degC per step
   // ****************************************************************
   localparam int TEMP_W = 12;
   typedef logic signed [TEMP_W-1:0] temp_t;
   typedef logic signed [TEMP_W:0]   tdiff_t;

   localparam temp_t ROOM_PREHEAT_MAX  = 12'sh0C8;   // 20.0
   localparam temp_t PREHEAT_OFF_MIN   = 12'sh000;   // 0.0
   localparam temp_t PREHEAT_BAND_LOW  = -12'sh03C;  // -6.0
   localparam temp_t ZONE_A_TOP        = -12'sh028;  // -4.0
   localparam temp_t ZONE_C_TOP        = -12'sh03C;  // -6.0
   localparam temp_t ZONE_B_TOP        = -12'sh0FA;  // -25.0
   localparam tdiff_t ZONE_A_DROP      = 13'sh0019;  // 2.5
   localparam tdiff_t ZONE_C_DROP      = 13'sh001E;  // 3.0
   localparam temp_t EXIT_HOT          = 12'sh050;   // 8.0
   localparam temp_t EXIT_WARM         = 12'sh032;   // 5.0
   localparam temp_t INDOOR_FAN_CUT    = 12'sh17C;   // 38.0

   // ****************************************************************
   // Times in their own units, then seconds
   // ****************************************************************
   localparam int unsigned PREHEAT_OFF_H     = 2;
   localparam int unsigned BASE_START_MIN    = 10;
   localparam int unsigned BASE_END_MIN      = 15;
   localparam int unsigned ZONE_HOLD_MIN     = 2;
   localparam int unsigned ENTRY_STOP_SEC    = 20;
   localparam int unsigned ENTRY_VALVE_SEC   = 10;
   localparam int unsigned WARM_HOLD_SEC     = 80;
   localparam int unsigned DEFROST_MAX_MIN   = 15;
   localparam int unsigned RETURN_STOP_SEC   = 50;
   localparam int unsigned RETURN_VALVE_SEC  = 40;

   localparam int unsigned PREHEAT_OFF_S = PREHEAT_OFF_H * SEC_PER_HOUR;
   localparam int unsigned BASE_START_S  = BASE_START_MIN * SEC_PER_MIN;
   localparam int unsigned BASE_END_S    = BASE_END_MIN * SEC_PER_MIN;
   localparam int unsigned ZONE_HOLD_S   = ZONE_HOLD_MIN * SEC_PER_MIN;
   localparam int unsigned DEFROST_MAX_S = DEFROST_MAX_MIN * SEC_PER_MIN;

   localparam int OFF_W  = 13;
   localparam int RUN_W  = 10;
   localparam int STEP_W = 10;

   // ****************************************************************
   // Sequencer states, zones, pre-heat levels
   // ****************************************************************
   typedef enum logic [1:0] {
      HEAT_S    = 2'b00,
      ENTRY_S   = 2'b01,
      DEFROST_S = 2'b10,
      RETURN_S  = 2'b11
   } seq_state_t;

   typedef enum logic [1:0] {
      ZONE_NONE = 2'b00,
      ZONE_A    = 2'b01,
      ZONE_B    = 2'b10,
      ZONE_C    = 2'b11
   } zone_t;

   typedef enum logic [1:0] {
      PREHEAT_OFF  = 2'b00,
      PREHEAT_MILD = 2'b01,
      PREHEAT_COLD = 2'b10
   } preheat_t;

   // ****************************************************************
   // Outdoor fan taps, index 0 is stop, packed with tap 15 first
   // ****************************************************************
   localparam int RPM_W = 10;
   typedef logic [15:0][RPM_W-1:0] rpm_tab_t;
   localparam rpm_tab_t RPM_SMALL = {10'h2EE, 10'h2EE, 10'h2EE, 10'h2BC, 10'h2BC, 10'h2BC,
      10'h2BC, 10'h258, 10'h258, 10'h1F4, 10'h1F4, 10'h1C2, 10'h186, 10'h12C, 10'h0C8, 10'h000};
   localparam rpm_tab_t RPM_MID   = {10'h348, 10'h348, 10'h348, 10'h2BC, 10'h2BC, 10'h2BC,
      10'h2BC, 10'h258, 10'h258, 10'h1F4, 10'h1F4, 10'h1C2, 10'h186, 10'h12C, 10'h0C8, 10'h000};
   localparam rpm_tab_t RPM_LARGE = {10'h398, 10'h398, 10'h398, 10'h2EE, 10'h2EE, 10'h2EE,
      10'h2EE, 10'h28A, 10'h28A, 10'h1F4, 10'h1F4, 10'h1C2, 10'h186, 10'h12C, 10'h0C8, 10'h000};
   localparam logic [1:0] MODEL_SMALL = 2'h0;
   localparam logic [1:0] MODEL_MID   = 2'h1;

endpackage

// File: core/sec_tick_if.sv
// One-second enable pulse passed from the timebase to its users.
// Assumes all parties run on the same clock.
interface sec_tick_if;
   logic sec;
   modport src (output sec);
   modport dst (input sec);
endinterface

// File: core/sec_timebase.sv
// Divider that makes a one-cycle pulse once per second.
// Assumes one clock, synchronous active-high reset.
module sec_timebase #(
   parameter int unsigned SEC_CYCLES = hp_seq_pkg::SEC_CYCLES
) (
   input  wire logic   clk_in,
   input  wire logic   rst_in,
   sec_tick_if.src     tick
);
   logic [31:0] count_q;
   logic [31:0] count_d;
   logic        pulse_q;
   logic        pulse_d;

   always_comb
   begin
      pulse_d = 1'b0;
      count_d = count_q + 32'h1;
      if (count_q >= 32'(SEC_CYCLES - 1))
      begin
         count_d = '0;
         pulse_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         count_q <= '0;
         pulse_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         pulse_q <= pulse_d;
      end
   end

   assign tick.sec = pulse_q;
endmodule

// File: core/hold_timer.sv
// Counts whole seconds while a condition holds; done once the limit is met.
// Assumes cond_in and clr_in come from logic on the same clock.
module hold_timer #(
   parameter int unsigned LIMIT_S = 1
) (
   input  wire logic   clk_in,
   input  wire logic   rst_in,
   sec_tick_if.dst     tick,
   input  wire logic   cond_in,
   input  wire logic   clr_in,
   output logic        done_out
);
   localparam int CW = $clog2(LIMIT_S + 1);
   localparam logic [CW-1:0] LIMIT = CW'(LIMIT_S);

   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;

   // Any gap in the condition restarts the count: the hold must be continuous
   always_comb
   begin
      count_d = count_q;
      if (!cond_in || clr_in)
         count_d = '0;
      else if (tick.sec && count_q < LIMIT)
         count_d = count_q + CW'(1);
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         count_q <= '0;
      else
         count_q <= count_d;
   end

   assign done_out = cond_in && !clr_in && (count_q >= LIMIT);
endmodule

// File: core/heat_pump_defrost_sequencer.sv
// Heating-mode sequencer: pre-heat, coil baseline, zone defrost, fan taps.
// Assumes inputs registered on clk_in; temperatures signed 0.1 degC steps.
//
// Operation
// RULE_01: Pre-heat only after heating, two hours stopped
// RULE_02: Pre-heat needs room at or below 20C
// RULE_03: Pre-heat level chosen by coil temperature band
// RULE_04: Pre-heat only when heating mode selected
// RULE_05: Coil minimum over minutes 10-15 is baseline
// RULE_06: Defrost detection and sequence only while heating
// RULE_07: Zone A: drop >= 2.5 for two minutes
// RULE_08: Zone B: two continuous minutes starts defrost
// RULE_09: Zone C: drop >= 3 for two minutes
// RULE_10: Entry holds compressor stopped twenty seconds
// RULE_11: Valve energised ten seconds after compressor stop
// RULE_12: Outdoor fan stops with compressor at entry
// RULE_13: Indoor fan stops at 38C or below
// RULE_14: Exit at 8C, or 5C for 80s
// RULE_15: Exit unconditionally after fifteen minutes of defrost
// RULE_16: Return holds compressor stopped fifty seconds
// RULE_17: Valve released forty seconds after compressor stop
// RULE_18: Outdoor fan restarts with the compressor
// RULE_19: Fifteen fan taps, 200 to 920 rpm
// RULE_20: Zones from fixed -4, -6, -25 thresholds
// RULE_21: Pre-heat off at 0C and above
module heat_pump_defrost_sequencer #(
   parameter int unsigned SEC_CYCLES = hp_seq_pkg::SEC_CYCLES
) (
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire logic               unit_on_in,
   input  wire logic               heat_mode_in,
   input  wire hp_seq_pkg::temp_t  room_temp_in,
   input  wire hp_seq_pkg::temp_t  outdoor_coil_temp_in,
   input  wire hp_seq_pkg::temp_t  indoor_coil_temp_in,
   input  wire logic [3:0]         fan_tap_in,
   input  wire logic [1:0]         fan_model_in,
   output logic                    comp_run_out,
   output logic                    valve_reverse_out,
   output logic                    outdoor_fan_run_out,
   output logic [9:0]              outdoor_fan_rpm_out,
   output logic                    indoor_fan_allow_out,
   output logic                    defrost_active_out,
   output hp_seq_pkg::preheat_t    preheat_level_out,
   output hp_seq_pkg::temp_t       coil_temp_baseline_out,
   output logic                    baseline_valid_out
);

   // ****************************************************************
   // Decoders
   // ****************************************************************
   // Colder zones are checked first so each reading lands in one zone only
   function automatic hp_seq_pkg::zone_t zone_of(input hp_seq_pkg::temp_t t);
      if (t <= hp_seq_pkg::ZONE_B_TOP)
         return hp_seq_pkg::ZONE_B;
      else if (t <= hp_seq_pkg::ZONE_C_TOP)
         return hp_seq_pkg::ZONE_C;
      else if (t <= hp_seq_pkg::ZONE_A_TOP)
         return hp_seq_pkg::ZONE_A;
      else
         return hp_seq_pkg::ZONE_NONE;
   endfunction

   function automatic logic [9:0] tap_rpm(input logic [1:0] model, input logic [3:0] tap);
      if (model == hp_seq_pkg::MODEL_SMALL)
         return hp_seq_pkg::RPM_SMALL[tap];
      else if (model == hp_seq_pkg::MODEL_MID)
         return hp_seq_pkg::RPM_MID[tap];
      else
         return hp_seq_pkg::RPM_LARGE[tap];
   endfunction

   localparam logic [hp_seq_pkg::OFF_W-1:0]  OFF_LIMIT   = 13'(hp_seq_pkg::PREHEAT_OFF_S);
   localparam logic [hp_seq_pkg::RUN_W-1:0]  BASE_START  = 10'(hp_seq_pkg::BASE_START_S);
   localparam logic [hp_seq_pkg::RUN_W-1:0]  BASE_END    = 10'(hp_seq_pkg::BASE_END_S);
   localparam logic [hp_seq_pkg::STEP_W-1:0] ENTRY_STOP  = 10'(hp_seq_pkg::ENTRY_STOP_SEC);
   localparam logic [hp_seq_pkg::STEP_W-1:0] ENTRY_VALVE = 10'(hp_seq_pkg::ENTRY_VALVE_SEC);
   localparam logic [hp_seq_pkg::STEP_W-1:0] RET_STOP    = 10'(hp_seq_pkg::RETURN_STOP_SEC);
   localparam logic [hp_seq_pkg::STEP_W-1:0] RET_VALVE   = 10'(hp_seq_pkg::RETURN_VALVE_SEC);
   localparam logic [hp_seq_pkg::STEP_W-1:0] DEF_MAX     = 10'(hp_seq_pkg::DEFROST_MAX_S);

   // ****************************************************************
   // Timebase and hold timers
   // ****************************************************************
   sec_tick_if tick ();

   logic heating_run;
   logic zone_cond;
   logic zone_clr;
   logic zone_done;
   logic warm_cond;
   logic warm_done;
   hp_seq_pkg::zone_t zone_now;
   hp_seq_pkg::tdiff_t coil_drop;

   sec_timebase #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_timebase (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .tick   (tick)
   );

   hold_timer #(
      .LIMIT_S (hp_seq_pkg::ZONE_HOLD_S)
   ) u_zone_hold (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .tick     (tick),
      .cond_in  (zone_cond),
      .clr_in   (zone_clr),
      .done_out (zone_done)
   );

   hold_timer #(
      .LIMIT_S (hp_seq_pkg::WARM_HOLD_SEC)
   ) u_warm_hold (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .tick     (tick),
      .cond_in  (warm_cond),
      .clr_in   (1'b0),
      .done_out (warm_done)
   );

   // ****************************************************************
   // Stop history and coil baseline
   // ****************************************************************
   logic                              was_on_q, was_on_d;
   logic                              last_heat_q, last_heat_d;
   logic [hp_seq_pkg::OFF_W-1:0]      off_sec_q, off_sec_d;
   logic [hp_seq_pkg::RUN_W-1:0]      run_sec_q, run_sec_d;
   hp_seq_pkg::temp_t                 base_q, base_d;
   logic                              base_seen_q, base_seen_d;
   logic                              base_valid_q, base_valid_d;

   assign heating_run = unit_on_in && heat_mode_in;

   always_comb
   begin
      was_on_d     = unit_on_in;
      last_heat_d  = last_heat_q;
      off_sec_d    = off_sec_q;
      run_sec_d    = run_sec_q;
      base_d       = base_q;
      base_seen_d  = base_seen_q;
      base_valid_d = base_valid_q;
      // Mode is caught at the stop edge; power-on counts as not heating
      if (was_on_q && !unit_on_in)
      begin
         last_heat_d = heat_mode_in;                     // see RULE_01
         off_sec_d   = '0;
      end
      else if (!unit_on_in && tick.sec && off_sec_q < OFF_LIMIT)
         off_sec_d = off_sec_q + 13'h1;                  // see RULE_01
      if (!heating_run)
      begin
         run_sec_d    = '0;
         base_seen_d  = 1'b0;
         base_valid_d = 1'b0;
      end
      else
      begin
         if (tick.sec && run_sec_q < BASE_END)
            run_sec_d = run_sec_q + 10'h1;
         if (run_sec_q >= BASE_START && run_sec_q < BASE_END)
         begin
            if (!base_seen_q || outdoor_coil_temp_in < base_q)
               base_d = outdoor_coil_temp_in;            // see RULE_05
            base_seen_d = 1'b1;
         end
         base_valid_d = base_seen_q && (run_sec_q >= BASE_END);   // see RULE_05
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         was_on_q     <= 1'b0;
         last_heat_q  <= 1'b0;
         off_sec_q    <= '0;
         run_sec_q    <= '0;
         base_q       <= '0;
         base_seen_q  <= 1'b0;
         base_valid_q <= 1'b0;
      end
      else
      begin
         was_on_q     <= was_on_d;
         last_heat_q  <= last_heat_d;
         off_sec_q    <= off_sec_d;
         run_sec_q    <= run_sec_d;
         base_q       <= base_d;
         base_seen_q  <= base_seen_d;
         base_valid_q <= base_valid_d;
      end
   end

   // ****************************************************************
   // Zone detection
   // ****************************************************************
   hp_seq_pkg::zone_t zone_q, zone_d;
   hp_seq_pkg::seq_state_t state_q, state_d;

   assign zone_now  = zone_of(outdoor_coil_temp_in);                          // see RULE_20
   assign coil_drop = hp_seq_pkg::tdiff_t'(base_q) - hp_seq_pkg::tdiff_t'(outdoor_coil_temp_in);

   always_comb
   begin
      zone_d    = zone_now;
      // Moving between zones restarts the two-minute hold
      zone_clr  = (zone_now != zone_q);
      zone_cond = 1'b0;
      if (heating_run && base_valid_q && state_q == hp_seq_pkg::HEAT_S)  // see RULE_06
      begin
         case (zone_now)
            hp_seq_pkg::ZONE_A: zone_cond = coil_drop >= hp_seq_pkg::ZONE_A_DROP;  // see RULE_07
            hp_seq_pkg::ZONE_B: zone_cond = 1'b1;                                  // see RULE_08
            hp_seq_pkg::ZONE_C: zone_cond = coil_drop >= hp_seq_pkg::ZONE_C_DROP;  // see RULE_09
            default:            zone_cond = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         zone_q <= hp_seq_pkg::ZONE_NONE;
      else
         zone_q <= zone_d;
   end

   // ****************************************************************
   // Defrost sequencer
   // ****************************************************************
   logic [hp_seq_pkg::STEP_W-1:0] step_q, step_d;

   assign warm_cond = (state_q == hp_seq_pkg::DEFROST_S) && (outdoor_coil_temp_in >= hp_seq_pkg::EXIT_WARM);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         hp_seq_pkg::HEAT_S:
            if (zone_done)
               state_d = hp_seq_pkg::ENTRY_S;
         hp_seq_pkg::ENTRY_S:
            if (step_q >= ENTRY_STOP)                    // see RULE_10
               state_d = hp_seq_pkg::DEFROST_S;
         hp_seq_pkg::DEFROST_S:
            if (outdoor_coil_temp_in >= hp_seq_pkg::EXIT_HOT || warm_done)   // see RULE_14
               state_d = hp_seq_pkg::RETURN_S;
            else if (step_q >= DEF_MAX)                  // see RULE_15
               state_d = hp_seq_pkg::RETURN_S;
         hp_seq_pkg::RETURN_S:
            if (step_q >= RET_STOP)                      // see RULE_16
               state_d = hp_seq_pkg::HEAT_S;
         default:
            state_d = hp_seq_pkg::HEAT_S;
      endcase
      // Leaving heating drops any sequence in progress
      if (!heating_run)
         state_d = hp_seq_pkg::HEAT_S;                   // see RULE_06
      step_d = step_q;
      if (state_d != state_q)
         step_d = '0;
      else if (tick.sec && step_q < DEF_MAX)
         step_d = step_q + 10'h1;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_q <= hp_seq_pkg::HEAT_S;
         step_q  <= '0;
      end
      else
      begin
         state_q <= state_d;
         step_q  <= step_d;
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   logic                 comp_q, comp_d;
   logic                 valve_q, valve_d;
   logic                 ofan_q, ofan_d;
   logic [9:0]           rpm_q, rpm_d;
   logic                 ifan_q, ifan_d;
   logic                 dfr_q, dfr_d;
   hp_seq_pkg::preheat_t pre_q, pre_d;

   always_comb
   begin
      comp_d  = heating_run && (state_q == hp_seq_pkg::HEAT_S || state_q == hp_seq_pkg::DEFROST_S);
      // Fan follows the compressor stop at entry and its restart on return
      ofan_d  = heating_run && (state_q == hp_seq_pkg::HEAT_S);          // see RULE_12, RULE_18
      rpm_d   = ofan_d ? tap_rpm(fan_model_in, fan_tap_in) : 10'h000;    // see RULE_19
      valve_d = 1'b0;
      case (state_q)
         hp_seq_pkg::ENTRY_S:   valve_d = step_q >= ENTRY_VALVE;          // see RULE_11
         hp_seq_pkg::DEFROST_S: valve_d = 1'b1;
         hp_seq_pkg::RETURN_S:  valve_d = step_q < RET_VALVE;             // see RULE_17
         default:               valve_d = 1'b0;
      endcase
      dfr_d  = state_q == hp_seq_pkg::ENTRY_S || state_q == hp_seq_pkg::DEFROST_S;
      ifan_d = !(dfr_d && indoor_coil_temp_in <= hp_seq_pkg::INDOOR_FAN_CUT);   // see RULE_13
      pre_d  = hp_seq_pkg::PREHEAT_OFF;
      // Winding heat is only for a stopped unit set to heat
      if (heat_mode_in && !unit_on_in && last_heat_q && off_sec_q >= OFF_LIMIT   // see RULE_01, RULE_04
          && room_temp_in <= hp_seq_pkg::ROOM_PREHEAT_MAX)                       // see RULE_02
      begin
         if (outdoor_coil_temp_in >= hp_seq_pkg::PREHEAT_OFF_MIN)
            pre_d = hp_seq_pkg::PREHEAT_OFF;                                     // see RULE_21
         else if (outdoor_coil_temp_in > hp_seq_pkg::PREHEAT_BAND_LOW)
            pre_d = hp_seq_pkg::PREHEAT_MILD;                                    // see RULE_03
         else
            pre_d = hp_seq_pkg::PREHEAT_COLD;                                    // see RULE_03
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         comp_q  <= 1'b0;
         valve_q <= 1'b0;
         ofan_q  <= 1'b0;
         rpm_q   <= '0;
         ifan_q  <= 1'b1;
         dfr_q   <= 1'b0;
         pre_q   <= hp_seq_pkg::PREHEAT_OFF;
      end
      else
      begin
         comp_q  <= comp_d;
         valve_q <= valve_d;
         ofan_q  <= ofan_d;
         rpm_q   <= rpm_d;
         ifan_q  <= ifan_d;
         dfr_q   <= dfr_d;
         pre_q   <= pre_d;
      end
   end

   assign comp_run_out           = comp_q;
   assign valve_reverse_out      = valve_q;
   assign outdoor_fan_run_out    = ofan_q;
   assign outdoor_fan_rpm_out    = rpm_q;
   assign indoor_fan_allow_out   = ifan_q;
   assign defrost_active_out     = dfr_q;
   assign preheat_level_out      = pre_q;
   assign coil_temp_baseline_out = base_q;
   assign baseline_valid_out     = base_valid_q;

endmodule

// File: bench/coil_model.sv
// Outdoor coil sensor model: follows a bench target, warms while reverse defrost runs.
// Assumes the sequencer's clock; SC clocks stand for one second.
module coil_model #(
   parameter int unsigned SC = 10
) (
   input  wire logic              clk_in,
   input  wire logic              comp_in,
   input  wire logic              valve_in,
   input  wire logic              hold_in,
   input  wire hp_seq_pkg::temp_t target_in,
   output hp_seq_pkg::temp_t      coil_out = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned n = 0;
   // Hold keeps the coil frozen so only the time cap can end a defrost
   always @(posedge clk_in)
   begin
      n <= (n == SC - 1) ? 0 : n + 1;
      if (!(comp_in && valve_in))
         coil_out <= target_in;
      else if (!hold_in && n == 0)
         coil_out <= coil_out + 12'sh002;
   end
endmodule

// File: bench/hp_seq_monitor.sv
// Checker of the sequencer's output timing, bound to its top module.
// Assumes one clock and the synchronous active-high reset.
module hp_seq_monitor (
   input wire logic                 clk_in,
   input wire logic                 rst_in,
   input wire logic                 unit_on_in,
   input wire logic                 heat_mode_in,
   input wire hp_seq_pkg::temp_t    indoor_coil_temp_in,
   input wire logic                 comp_run_out,
   input wire logic                 valve_reverse_out,
   input wire logic                 outdoor_fan_run_out,
   input wire logic [9:0]           outdoor_fan_rpm_out,
   input wire logic                 indoor_fan_allow_out,
   input wire logic                 defrost_active_out,
   input wire hp_seq_pkg::preheat_t preheat_level_out,
   input wire hp_seq_pkg::temp_t    coil_temp_baseline_out,
   input wire logic                 baseline_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   chk_entry_stop:
      assert property ($rose(defrost_active_out) |-> !comp_run_out && !outdoor_fan_run_out)
      else $error("Compressor or fan ran at defrost entry");
   chk_valve_delay:
      assert property ($rose(defrost_active_out) |-> !valve_reverse_out [*8])
      else $error("Valve reversed too early");
   chk_heat_only:
      assert property (!(unit_on_in && heat_mode_in) |-> ##3 !defrost_active_out && !valve_reverse_out)
      else $error("Defrost kept outside heating");
   chk_indoor_cut:
      assert property ((defrost_active_out && indoor_coil_temp_in <= hp_seq_pkg::INDOOR_FAN_CUT) [*3]
         |-> !indoor_fan_allow_out)
      else $error("Indoor fan allowed on cold coil");
   chk_fan_restart:
      assert property ($rose(comp_run_out) && !defrost_active_out |-> outdoor_fan_run_out)
      else $error("Fan not restarted with compressor");
   chk_rpm_zero:
      assert property (!outdoor_fan_run_out |-> outdoor_fan_rpm_out == 10'h000)
      else $error("Rpm shown with fan stopped");
   chk_base_hold:
      assert property (baseline_valid_out && $past(baseline_valid_out) |-> $stable(coil_temp_baseline_out))
      else $error("Baseline moved after window");
   chk_no_preheat:
      assert property (unit_on_in && $past(unit_on_in, 2) |-> preheat_level_out == hp_seq_pkg::PREHEAT_OFF)
      else $error("Pre-heat while running");
   chk_return_hold:
      assert property ($fell(defrost_active_out) && unit_on_in && heat_mode_in
         |-> (valve_reverse_out && !comp_run_out) [*8])
      else $error("Return step wrong");
endmodule
bind heat_pump_defrost_sequencer hp_seq_monitor hp_seq_monitor_i (.*);

// File: bench/heat_pump_defrost_sequencer_test.sv
// Self-checking bench of the defrost sequencer with a coil sensor model.
// Assumes SEC_CYCLES shortened to 10 clocks so one second is 100 ns.
module heat_pump_defrost_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned SC = 10;
   logic                 clk_in = 1'b0, rst_in = 1'b1, unit_on = 1'b0, heat_mode = 1'b0, hold = 1'b0;
   logic [3:0]           tap = 4'hF;
   logic [1:0]           model = 2'h1;
   hp_seq_pkg::temp_t    room = 12'sh0FA, target = -12'sh014, indoor = 12'sh12C, coil, base;
   logic                 comp, valve, fan, allow, dfr, base_ok;
   logic [9:0]           rpm;
   hp_seq_pkg::preheat_t pre;
   int                   err_total = 0, n_compared = 0, n;
   always #5 clk_in = ~clk_in;
   coil_model #(.SC(SC)) coil_model_i (.clk_in, .comp_in(comp), .valve_in(valve), .hold_in(hold),
      .target_in(target), .coil_out(coil));
   heat_pump_defrost_sequencer #(.SEC_CYCLES(SC)) heat_pump_defrost_sequencer_i (.clk_in, .rst_in,
      .unit_on_in(unit_on), .heat_mode_in(heat_mode), .room_temp_in(room), .outdoor_coil_temp_in(coil),
      .indoor_coil_temp_in(indoor), .fan_tap_in(tap), .fan_model_in(model), .comp_run_out(comp),
      .valve_reverse_out(valve), .outdoor_fan_run_out(fan), .outdoor_fan_rpm_out(rpm),
      .indoor_fan_allow_out(allow), .defrost_active_out(dfr), .preheat_level_out(pre),
      .coil_temp_baseline_out(base), .baseline_valid_out(base_ok));
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait; a hang ends the run as a mismatch
   task automatic wait_for(ref logic sig, input logic lvl, input int lim);
      n = 0;
      while (sig !== lvl && n < lim)
      begin
         @(negedge clk_in);
         n++;
      end
      check("wait", lvl, sig);
      if (sig !== lvl)
         results();
   endtask
   task automatic ticks(int k);
      repeat (k * SC) @(negedge clk_in);
   endtask
   task automatic test_baseline();
      unit_on = 1'b1;
      heat_mode = 1'b1;
      target = -12'sh03C;
      ticks(100);
      target = -12'sh014;
      ticks(600);
      target = -12'sh01E;
      ticks(50);
      target = -12'sh014;
      wait_for(base_ok, 1'b1, 3000);
      check("baseline", -12'sh01E, base);
      $display("baseline done");
   endtask
   task automatic test_zone_a();
      target = -12'sh037;
      ticks(115);
      check("early entry", 0, dfr);
      wait_for(dfr, 1'b1, 200);
      check("entry comp", 0, comp);
      check("entry fan", 0, {fan, rpm});
      ticks(5);
      check("valve early", 0, valve);
      ticks(7);
      check("valve on", 1, valve);
      ticks(6);
      check("comp held", 0, comp);
      check("indoor cut", 0, allow);
      wait_for(comp, 1'b1, 60);
      indoor = 12'sh190;
      ticks(1);
      check("indoor warm", 1, allow);
      wait_for(dfr, 1'b0, 2000);
      target = -12'sh014;
      check("exit hot", 1, coil >= hp_seq_pkg::EXIT_HOT);
      ticks(35);
      check("return valve", 1, valve);
      ticks(10);
      check("valve off", 0, valve);
      check("return comp", 0, comp);
      wait_for(comp, 1'b1, 100);
      check("fan restart", 1, fan);
      $display("zone A done");
   endtask
   task automatic test_taps();
      for (int m = 0; m < 4; m++)
         for (int t = 0; t < 16; t++)
         begin
            model = 2'(m);
            tap = 4'(t);
            repeat (3) @(negedge clk_in);
            check("rpm", m == 0 ? hp_seq_pkg::RPM_SMALL[t] : m == 1 ? hp_seq_pkg::RPM_MID[t]
               : hp_seq_pkg::RPM_LARGE[t], rpm);
         end
      $display("taps done");
   endtask
   task automatic test_cap();
      wait_for(base_ok, 1'b1, 10000);
      hold = 1'b1;
      target = -12'sh104;
      wait_for(dfr, 1'b1, 1400);
      check("zone B hold", 1, n >= 1170);
      wait_for(dfr, 1'b0, 9400);
      check("time cap", 1, n >= 9170 && n <= 9210);
      wait_for(dfr, 1'b1, 2500);
      heat_mode = 1'b0;
      ticks(1);
      check("abort", 0, {dfr, valve});
      heat_mode = 1'b1;
      unit_on = 1'b0;
      ticks(2);
      check("no pre-heat", hp_seq_pkg::PREHEAT_OFF, pre);
      $display("cap done");
   endtask
   initial
   begin
      repeat (4) @(negedge clk_in);
      rst_in = 1'b0;
      test_baseline();
      test_zone_a();
      test_taps();
      test_cap();
      results();
   end
endmodule
